// [core/sbt_pkg.sv]
// Package with register map, field positions and timing constants of the interval timer
`default_nettype none
package sbt_pkg;
    // Register byte addresses (chosen, no offsets given)
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
    localparam logic [7:0] ADDR_COUNT_HI  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CTRL  = 8'h18;
    // Control field positions
    localparam int RUN_BIT      = 0;
    localparam int SOURCE_BIT   = 1;
    localparam int PRESCALE_LSB = 4;
    localparam logic [7:0] CONTROL_MASK  = 8'h33;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Interrupt control field positions
    localparam int GLOBAL_EN_BIT = 0;
    localparam int PERIPH_EN_BIT = 1;
    // Oscillator, instruction and core clock rates in Hz, phase accumulator width and steps
    localparam int OSC_HZ     = 8000000;
    localparam int INSTR_HZ   = 2000000;
    localparam int CORE_HZ    = 10000000;
    localparam int PHASE_W    = 24;
    localparam logic [PHASE_W-1:0] PHASE_MOD = PHASE_W'(CORE_HZ);
    localparam logic [PHASE_W-1:0] OSC_STEP  = PHASE_W'(OSC_HZ);
    localparam logic [PHASE_W-1:0] INSTR_STEP = PHASE_W'(INSTR_HZ);
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hffff;

    typedef struct packed {
        logic [1:0] prescaleSelect;
        logic       sourceSelect;
        logic       runControl;
    } sbt_ctrl_t;
endpackage
`default_nettype wire

// [core/sixteen_bit_interval_timer.sv]
// Sixteen-bit interval timer with APB register access and rollover interrupt
//
// Added by the designer: the register addresses and register access over APB.
`default_nettype none
// Function
// RL1: 16-bit up-counter read and written as two bytes; writes replace live count.
// RL2: Counting only while run bit 0 set; clearing halts and resets gate flop.
// RL3: Source bit 1 picks oscillator when one, instruction clock when zero.
// RL4: Prescale field bits 5-4 divides by 1, 2, 4 or 8.
// RL5: Prescaler hidden from software; cleared on any count byte write.
// RL6: Wrap from maximum to zero sets the rollover flag.
// RL7: Interrupt needs run bit, local, peripheral and global enables all set.
// RL8: Rollover flag stays set until software clears it.
// RL9: Software should clear count and flag before enabling interrupts.
// RL10: Timer frozen in sleep and never wakes the device.
// RL11: Control bits 7-6 and 3-2 ignore writes, read zero.
// RL12: Oscillator source at 1:1 advances count four per instruction cycle.
// RL13: Control bits reset to zero: stopped, instruction clock, 1:1.
// RL14: Count reads have no side effects on prescaler or flag.
module sixteen_bit_interval_timer (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // System
    input  wire logic        sleepMode,
    output logic             irqOut
);
    sbt_pkg::sbt_ctrl_t ctrl_ff;
    logic [15:0] count_ff;
    logic [2:0]  prescale_ff;
    logic        gate_ff;
    logic        flag_ff;
    logic        irqEnable_ff;
    logic        globalEn_ff;
    logic        periphEn_ff;
    logic [sbt_pkg::PHASE_W-1:0] phase_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        irq_ff;

    logic        access;
    logic        wrEn;
    logic        wrCtrl;
    logic        wrLow;
    logic        wrHigh;
    logic        mapped;
    logic [sbt_pkg::PHASE_W-1:0] step;
    logic [sbt_pkg::PHASE_W:0]   phaseSum;
    logic        srcTick;
    logic [2:0]  nxt_prescale;
    logic        preTick;
    logic        divDone;
    logic [2:0]  divMask;
    logic        countTick;
    logic        rollover;
    logic [31:0] nxt_prdata;
    logic [15:0] nxt_count;
    logic        nxt_flag;
    logic        nxt_irq;
    logic        nxt_pready;
    logic        nxt_pslverr;
    logic        wrClear;
    logic        wrIrqEn;
    logic        wrIrqCtrl;
    logic        countWr;
    logic        runGate;
    logic [7:0]  ctrlRead;
    sbt_pkg::sbt_ctrl_t ctrlWrite;

    // Bus decode; two-cycle access phase, access pulses in its first cycle
    assign access = psel && penable && !pready_ff;
    assign wrEn   = access && pwrite && pstrb[0];
    assign wrCtrl = wrEn && (paddr == sbt_pkg::ADDR_CONTROL);
    assign wrLow  = wrEn && (paddr == sbt_pkg::ADDR_COUNT_LOW);
    assign wrHigh = wrEn && (paddr == sbt_pkg::ADDR_COUNT_HI);
    assign wrClear   = wrEn && (paddr == sbt_pkg::ADDR_IRQ_CLEAR);
    assign wrIrqEn   = wrEn && (paddr == sbt_pkg::ADDR_IRQ_EN);
    assign wrIrqCtrl = wrEn && (paddr == sbt_pkg::ADDR_IRQ_CTRL);
    assign countWr   = wrLow || wrHigh;

    always_comb
    begin
        case (paddr)
            sbt_pkg::ADDR_CONTROL,
            sbt_pkg::ADDR_COUNT_LOW,
            sbt_pkg::ADDR_COUNT_HI,
            sbt_pkg::ADDR_IRQ_STAT,
            sbt_pkg::ADDR_IRQ_CLEAR,
            sbt_pkg::ADDR_IRQ_EN,
            sbt_pkg::ADDR_IRQ_CTRL: mapped = 1'b1;
            default:                mapped = 1'b0;
        endcase
    end

    // Source clock ticks by phase accumulation against the core clock
    assign step = ctrl_ff.sourceSelect ? sbt_pkg::OSC_STEP : sbt_pkg::INSTR_STEP; // RL3
    assign phaseSum = {1'b0, phase_ff} + {1'b0, step};
    assign runGate = gate_ff && !sleepMode; // RL2 RL10
    assign srcTick = runGate && (phaseSum >= {1'b0, sbt_pkg::PHASE_MOD}); // RL10

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            phase_ff <= '0;
        else if (!gate_ff)
            phase_ff <= '0; // RL2
        else if (sleepMode)
            phase_ff <= phase_ff; // RL10
        else if (srcTick)
            phase_ff <= sbt_pkg::PHASE_W'(phaseSum - {1'b0, sbt_pkg::PHASE_MOD});
        else
            phase_ff <= phaseSum[sbt_pkg::PHASE_W-1:0];
    end

    // Prescaler: tick passes when the low bits selected by the field are all one
    always_comb
    begin
        case (ctrl_ff.prescaleSelect) // RL4
            2'b00:   divMask = 3'h0;
            2'b01:   divMask = 3'h1;
            2'b10:   divMask = 3'h3;
            default: divMask = 3'h7;
        endcase
    end
    assign divDone = ((prescale_ff & divMask) == divMask);
    assign preTick = srcTick && divDone;
    assign nxt_prescale = divDone ? 3'h0 : prescale_ff + 3'h1;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            prescale_ff <= 3'h0;
        else if (countWr || !gate_ff)
            prescale_ff <= 3'h0; // RL5
        else if (srcTick)
            prescale_ff <= nxt_prescale;
    end

    // Gate flip-flop follows the run bit
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            gate_ff <= 1'b0;
        else
            gate_ff <= ctrl_ff.runControl; // RL2
    end

    // Counter; oscillator at 1:1 gives four ticks per instruction cycle
    assign countTick = preTick && ctrl_ff.runControl; // RL2 RL12
    assign rollover  = countTick && (count_ff == sbt_pkg::COUNT_MAX) && !countWr; // RL6

    always_comb
    begin
        nxt_count = count_ff;
        if (wrLow)
            nxt_count = {count_ff[15:8], pwdata[7:0]}; // RL1
        else if (wrHigh)
            nxt_count = {pwdata[7:0], count_ff[7:0]}; // RL1
        else if (countTick)
            nxt_count = count_ff + 16'h0001; // RL1
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            count_ff <= sbt_pkg::COUNT_RESET;
        else
            count_ff <= nxt_count;
    end

    // Control register; only the implemented fields are stored
    assign ctrlWrite = {pwdata[sbt_pkg::PRESCALE_LSB+1:sbt_pkg::PRESCALE_LSB],
                        pwdata[sbt_pkg::SOURCE_BIT],
                        pwdata[sbt_pkg::RUN_BIT]}; // RL11

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_ff <= sbt_pkg::sbt_ctrl_t'({
                sbt_pkg::CONTROL_RESET[sbt_pkg::PRESCALE_LSB+1:sbt_pkg::PRESCALE_LSB],
                sbt_pkg::CONTROL_RESET[sbt_pkg::SOURCE_BIT],
                sbt_pkg::CONTROL_RESET[sbt_pkg::RUN_BIT]}); // RL13
        else if (wrCtrl)
            ctrl_ff <= ctrlWrite;
    end

    // Rollover flag, set wins over clear
    always_comb
    begin
        nxt_flag = flag_ff;
        if (rollover)
            nxt_flag = 1'b1; // RL6
        else if (wrClear && pwdata[0])
            nxt_flag = 1'b0; // RL8
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end

    // Local rollover interrupt enable
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irqEnable_ff <= 1'b0;
        else if (wrIrqEn)
            irqEnable_ff <= pwdata[0]; // RL7
    end

    // Global and peripheral interrupt enables
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            globalEn_ff <= 1'b0;
            periphEn_ff <= 1'b0;
        end
        else if (wrIrqCtrl)
        begin
            globalEn_ff <= pwdata[sbt_pkg::GLOBAL_EN_BIT]; // RL7
            periphEn_ff <= pwdata[sbt_pkg::PERIPH_EN_BIT]; // RL7
        end
    end

    // Interrupt output; gated by sleep so it never wakes the device
    assign nxt_irq = flag_ff && irqEnable_ff && periphEn_ff && globalEn_ff
                     && ctrl_ff.runControl && !sleepMode; // RL7 RL10

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= nxt_irq;
    end

    // Read data; reads have no side effects
    assign ctrlRead = {2'b00, ctrl_ff.prescaleSelect, 2'b00, ctrl_ff.sourceSelect,
                       ctrl_ff.runControl}; // RL11

    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        case (paddr) // RL14
            sbt_pkg::ADDR_CONTROL:   nxt_prdata[7:0] = ctrlRead;
            sbt_pkg::ADDR_COUNT_LOW: nxt_prdata[7:0] = count_ff[7:0];
            sbt_pkg::ADDR_COUNT_HI:  nxt_prdata[7:0] = count_ff[15:8];
            sbt_pkg::ADDR_IRQ_STAT:  nxt_prdata[0]   = flag_ff;
            sbt_pkg::ADDR_IRQ_EN:    nxt_prdata[0]   = irqEnable_ff;
            sbt_pkg::ADDR_IRQ_CTRL:  nxt_prdata[1:0] = {periphEn_ff, globalEn_ff};
            default:                 nxt_prdata = 32'h0000_0000;
        endcase
    end

    // APB answer one cycle into the access phase
    assign nxt_pready  = access;
    assign nxt_pslverr = access && !mapped;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pready_ff <= 1'b0;
        else
            pready_ff <= nxt_pready;
    end

    // Error flag for unmapped addresses, given with the answer
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pslverr_ff <= 1'b0;
        else
            pslverr_ff <= nxt_pslverr;
    end

    // Read data captured once per read access and held
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            prdata_ff <= 32'h0000_0000;
        else if (access && !pwrite)
            prdata_ff <= nxt_prdata; // RL14
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign irqOut  = irq_ff;
endmodule // sixteen_bit_interval_timer
`default_nettype wire

// [dv/sbt_checker.sv]
// Port assertions for the interval timer
`default_nettype none
module sbt_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // System
    input wire logic        sleepMode,
    input wire logic        irqOut
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    sequence acc_s;
        psel && penable && !pready;
    endsequence
    sequence rd_s;
        pready && !pwrite;
    endsequence
    wait_state_a: assert property (acc_s |=> pready)
        else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("long ready");
    ctrl_unused_a: assert property (rd_s and (paddr == sbt_pkg::ADDR_CONTROL)
        |-> prdata[31:6] == 0 && prdata[3:2] == 0) else $error("unused bits set");
    count_byte_a: assert property (rd_s and (paddr == sbt_pkg::ADDR_COUNT_LOW
        || paddr == sbt_pkg::ADDR_COUNT_HI) |-> prdata[31:8] == 0) else $error("wide count");
    flag_width_a: assert property (rd_s and (paddr == sbt_pkg::ADDR_IRQ_STAT)
        |-> prdata[31:1] == 0) else $error("wide status");
    irq_gate_a: assert property (pready && pwrite && pstrb[0] &&
        paddr == sbt_pkg::ADDR_IRQ_CTRL && pwdata[1:0] != 2'h3 |=> !irqOut [*3])
        else $error("irq not gated");
    sleep_mask_a: assert property (sleepMode |=> !irqOut)
        else $error("irq in sleep");
    flag_hold_a: assert property (irqOut && !sleepMode && !(psel && pwrite)
        |=> irqOut) else $error("irq dropped");
endmodule // sbt_checker
`default_nettype wire

// [dv/sixteen_bit_interval_timer_tb.sv]
// Self-checking testbench for the interval timer
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module sixteen_bit_interval_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, resetn = 1'b0, sleepMode = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, irqOut, err;
    logic [15:0] cnt;
    int          n_errors = 0, cmp_count = 0, ex;
    always #50 core_clk = ~core_clk;
    sixteen_bit_interval_timer i_sixteen_bit_interval_timer (.core_clk(core_clk),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleepMode(sleepMode), .irqOut(irqOut));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic setcnt(input logic [15:0] v);
        xfer(1'b1, sbt_pkg::ADDR_COUNT_LOW, {24'h0, v[7:0]});
        xfer(1'b1, sbt_pkg::ADDR_COUNT_HI, {24'h0, v[15:8]});
    endtask
    task automatic getcnt();
        xfer(1'b0, sbt_pkg::ADDR_COUNT_LOW, 32'h0);
        cnt[7:0] = rdat[7:0];
        xfer(1'b0, sbt_pkg::ADDR_COUNT_HI, 32'h0);
        cnt[15:8] = rdat[7:0];
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        xfer(1'b0, sbt_pkg::ADDR_CONTROL, 32'h0);
        `CHK(rdat, 32'h0)
        xfer(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'hff);
        xfer(1'b0, sbt_pkg::ADDR_CONTROL, 32'h0);
        `CHK(rdat, 32'h33)
        xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h0);
        setcnt(16'ha55a);
        getcnt();
        `CHK(cnt, 16'ha55a)
        $display("test registers done");
        for (int k = 0; k < 5; k++)
        begin
            setcnt(16'h0);
            xfer(1'b1, sbt_pkg::ADDR_CONTROL, (k < 4) ? 32'({k[1:0], 4'h3}) : 32'h1);
            repeat (1000) @(posedge core_clk);
            xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h0);
            getcnt();
            ex = (k < 4) ? (800 >> k) : 200;
            `CHK(cnt >= ex - 4 && cnt <= ex + 4, 1'b1)
        end
        repeat (50) @(posedge core_clk);
        ex = cnt;
        getcnt();
        `CHK(cnt, ex[15:0])
        setcnt(16'h0);
        sleepMode <= 1'b1;
        xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h3);
        repeat (100) @(posedge core_clk);
        xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h0);
        sleepMode <= 1'b0;
        getcnt();
        `CHK(cnt, 16'h0)
        $display("test rates done");
        setcnt(16'h0);
        xfer(1'b1, sbt_pkg::ADDR_IRQ_CLEAR, 32'h1);
        xfer(1'b1, sbt_pkg::ADDR_IRQ_EN, 32'h1);
        xfer(1'b1, sbt_pkg::ADDR_IRQ_CTRL, 32'h3);
        xfer(1'b0, sbt_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h0)
        setcnt(16'hfff0);
        xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h3);
        repeat (40) @(posedge core_clk);
        `CHK(irqOut, 1'b1)
        getcnt();
        xfer(1'b0, sbt_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h1)
        xfer(1'b1, sbt_pkg::ADDR_IRQ_CTRL, 32'h2);
        `CHK(irqOut, 1'b0)
        xfer(1'b1, sbt_pkg::ADDR_IRQ_CTRL, 32'h3);
        `CHK(irqOut, 1'b1)
        sleepMode <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK(irqOut, 1'b0)
        sleepMode <= 1'b0;
        xfer(1'b1, sbt_pkg::ADDR_CONTROL, 32'h0);
        `CHK(irqOut, 1'b0)
        xfer(1'b0, sbt_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h1)
        xfer(1'b1, sbt_pkg::ADDR_IRQ_CLEAR, 32'h1);
        xfer(1'b0, sbt_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rdat, 32'h0)
        $display("test rollover done");
        final_report();
    end
endmodule // sixteen_bit_interval_timer_tb
bind sixteen_bit_interval_timer sbt_checker i_sbt_checker (.core_clk(core_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .sleepMode(sleepMode), .irqOut(irqOut));
`default_nettype wire
